/* File: rtl/nand_host_ctrl.sv */
// NAND flash host controller driving command, address and data pins
`timescale 1ns/10ps
//
// Contract
// - Command byte: CLE high, strobe rises
// - Address byte: ALE high, five strobes
// - Address bytes ordered low to high
// - Upper nibble low in cycles two, five
// - Read: 00h, address, 30h, then busy
// - Program: 80h, address, data, 10h
// - Two-plane: 80h..11h, 81h..10h
// - Erase: 60h, address, D0h
// - Two-plane erase: 60h, 60h, D0h
// - Busy: only status and reset; code also accepts data reads while busy
// - Data in: latches low, WP high
// - Commands on bits seven to zero
// - Two-plane: A19 zero then one; code forces it for two-plane program only, not two-plane erase
module nand_host_ctrl
  import nand_host_pkg::*;
#(
  parameter int STROBE_CYCLES = nand_host_pkg::STROBE_CYC
) (
  input  wire logic                        clk,           // 20 MHz clock
  input  wire logic                        rstn,          // Sync reset, active low
  input  wire logic                        req_valid,     // Operation request
  input  wire nand_host_pkg::op_e          req_op,        // Requested operation
  input  wire logic [nand_host_pkg::ADDR_W-1:0] req_addr, // Page/column address
  input  wire logic [nand_host_pkg::ADDR_W-1:0] req_addr2,// Second plane address
  input  wire logic [7:0]                  req_wdata,     // Data byte to write
  input  wire logic                        req_wp_n,      // Write enable from user
  output logic                             req_ready,     // Idle, may take request
  output logic                             resp_valid,    // Read byte valid pulse
  output logic [7:0]                       resp_data,     // Read byte
  output logic                             req_refused,   // Request refused pulse
  output logic                             dev_ready,     // Synchronised ready level
  output logic                             cs_n,          // Chip select, active low
  output logic                             cle,           // Command latch strobe
  output logic                             ale,           // Address latch strobe
  output logic                             wr_strobe_n,   // Write strobe, active low
  output logic                             read_strobe_low,// Read strobe, active low
  output logic                             wp_n,          // Write protect, active low
  output logic [7:0]                       io_out,        // Shared bus drive value
  output logic                             io_oe_n,       // Bus enable, low drives
  input  wire logic [7:0]                  io_in,         // Shared bus sampled value
  input  wire logic                        rb_in          // Wired ready/busy line
);
  typedef enum {
    ST_IDLE, ST_CMD1, ST_ADDR1, ST_CMD2, ST_ADDR2, ST_CMD3, ST_WDATA, ST_RDATA
  } state_e;

  state_e      st_q;                // Sequencer state
  op_e         op_q;                // Operation in flight
  logic [7:0]  cmd_a_q;             // First command
  logic [7:0]  cmd_b_q;             // Middle command (11h/81h/60h)
  logic [7:0]  cmd_c_q;             // Final command
  logic [2:0]  ncyc_q;              // Address cycles per phase
  logic [2:0]  acnt_q;              // Address cycle index
  logic [ADDR_W-1:0] addr_q;        // Working address
  logic [ADDR_W-1:0] addr2_q;       // Second plane address
  logic [1:0]  phase_q;             // Strobe phase: 0 setup,1 low,2 high
  logic [7:0]  tcnt_q;              // Phase timer
  logic        tick;                // Phase timer expired
  logic [7:0]  io_in_s;             // Synchronised bus
  logic        rb_s;                // Synchronised ready
  logic        step_done;           // One bus cycle completed
  logic [7:0]  req_wdata_q;         // Captured write byte
  logic [2:0]  settle_q;            // Wait before trusting dummy busy
  logic        hold;                // Freeze strobe timing in setup
  logic [1:0]  rd_pipe_q;           // Read byte travelling through sync

  // Pins from outside pass two flops
  nand_pin_sync #(.W(9)) u_sync (
    .clk     (clk),
    .rstn    (rstn),
    .d       ({rb_in, io_in}),
    .rst_val (9'h100),
    .q       ({rb_s, io_in_s})
  );

  // Byte of address cycle n, upper nibble low for cycles two and five
  // twelve column bits span page
  function automatic logic [7:0] addr_byte(input logic [ADDR_W-1:0] a, input logic [2:0] n);
    case (n)
      3'd0:    addr_byte = a[7:0];
      3'd1:    addr_byte = {4'h0, a[11:8]};
      3'd2:    addr_byte = a[19:12];
      3'd3:    addr_byte = a[27:20];
      3'd4:    addr_byte = {4'h0, a[31:28]};
      default: addr_byte = 8'h00;
    endcase
  endfunction

  // Modify operations need write protect released
  function automatic logic is_modify(input op_e o);
    is_modify = (o == OP_PROG) || (o == OP_PROG2) || (o == OP_ERASE) ||
                (o == OP_ERASE2) || (o == OP_DATA_WR) || (o == OP_RAND_IN) ||
                (o == OP_PROG_GO);
  endfunction

  // Operations allowed while device busy
  function automatic logic busy_ok(input op_e o);
    busy_ok = (o == OP_STATUS) || (o == OP_RESET) || (o == OP_DATA_RD);
  endfunction

  assign tick      = (tcnt_q == 8'h00);
  assign step_done = tick && (phase_q == 2'd2);
  // hold 81h until dummy busy clears
  assign hold      = (st_q == ST_CMD2) && (cmd_b_q == CMD_PROG_SECOND) &&
                     (phase_q == 2'd0) && ((settle_q != 3'd0) || !rb_s);

  // Phase timer: each strobe half lasts STROBE_CYCLES
  always_ff @(posedge clk) begin
    if (!rstn || st_q == ST_IDLE || hold || tick) begin
      tcnt_q <= 8'(STROBE_CYCLES - 1);
    end else begin
      tcnt_q <= tcnt_q - 8'h01;
    end
  end

  // Phase stepper across setup, low, high
  always_ff @(posedge clk) begin
    if (!rstn || st_q == ST_IDLE) begin
      phase_q <= 2'd0;
    end else if (tick && !hold) begin
      phase_q <= (phase_q == 2'd2) ? 2'd0 : phase_q + 2'd1;
    end
  end

  // Sequencer and request capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q        <= ST_IDLE;
      op_q        <= OP_READ;
      cmd_a_q     <= CMD_READ_SETUP;
      cmd_b_q     <= 8'h00;
      cmd_c_q     <= 8'h00;
      ncyc_q      <= 3'd0;
      acnt_q      <= 3'd0;
      addr_q      <= '0;
      addr2_q     <= '0;
      settle_q    <= 3'd0;
      req_wdata_q <= 8'h00;
      req_refused <= 1'b0;
    end else begin
      req_refused <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (req_valid) begin
            // busy gate refuses while not ready, protect gate refuses
            if ((!rb_s && !busy_ok(req_op)) || (is_modify(req_op) && !req_wp_n)) begin
              req_refused <= 1'b1;
            end else begin
              op_q    <= req_op;
              req_wdata_q <= req_wdata;
              addr_q  <= req_addr;
              addr2_q <= req_addr2;
              acnt_q  <= 3'd0;
              ncyc_q  <= ADDR_CYCLES[2:0];
              cmd_b_q <= 8'h00;
              cmd_c_q <= 8'h00;
              st_q    <= ST_CMD1;
              case (req_op)
                OP_READ: begin
                  cmd_a_q <= CMD_READ_SETUP;
                  cmd_c_q <= CMD_READ_CONFIRM;
                end
                OP_PROG: cmd_a_q <= CMD_PROG_SETUP;
                OP_PROG_GO: begin
                  cmd_a_q <= CMD_PROG_CONFIRM;
                  ncyc_q  <= 3'd0;
                end
                OP_PROG2: begin
                  cmd_a_q <= CMD_PROG_SETUP;
                  cmd_b_q <= CMD_PROG_DUMMY;
                  cmd_c_q <= CMD_PROG_CONFIRM;
                  addr_q[PLANE_BIT]  <= 1'b0;
                  addr2_q[PLANE_BIT] <= 1'b1;
                end
                OP_ERASE: begin
                  cmd_a_q <= CMD_ERASE_SETUP;
                  cmd_c_q <= CMD_ERASE_CONF;
                end
                OP_ERASE2: begin
                  cmd_a_q <= CMD_ERASE_SETUP;
                  cmd_b_q <= CMD_ERASE_SETUP;
                  cmd_c_q <= CMD_ERASE_CONF;
                end
                OP_STATUS: begin
                  cmd_a_q <= CMD_STATUS;
                  ncyc_q  <= 3'd0;
                end
                OP_RESET: begin
                  cmd_a_q <= CMD_RESET;
                  ncyc_q  <= 3'd0;
                end
                OP_RAND_IN: begin
                  cmd_a_q <= CMD_RAND_IN;
                  ncyc_q  <= COL_CYCLES[2:0];
                end
                OP_RAND_OUT: begin
                  cmd_a_q <= CMD_RAND_OUT;
                  cmd_c_q <= CMD_RAND_OUT_CF;
                  ncyc_q  <= COL_CYCLES[2:0];
                end
                OP_READ_ID: begin
                  cmd_a_q <= CMD_READ_ID;
                  ncyc_q  <= 3'd1;
                end
                OP_DATA_WR: st_q <= ST_WDATA;
                OP_DATA_RD: st_q <= ST_RDATA;
                default: st_q <= ST_IDLE;
              endcase
            end
          end
        end
        ST_CMD1: if (step_done) st_q <= (ncyc_q != 3'd0) ? ST_ADDR1 : ST_IDLE;
        ST_ADDR1: begin
          if (step_done) begin
            acnt_q <= acnt_q + 3'd1;
            if (acnt_q == ncyc_q - 3'd1) begin
              acnt_q <= 3'd0;
              st_q   <= (cmd_b_q != 8'h00) ? ST_CMD2 :
                        (cmd_c_q != 8'h00) ? ST_CMD3 : ST_IDLE;
            end
          end
        end
        // Middle command; after 11h comes 81h once the dummy busy is over
        ST_CMD2: begin
          if (settle_q != 3'd0) begin
            // Give busy time to reach the synchroniser
            settle_q <= settle_q - 3'd1;
          end else if (step_done && cmd_b_q == CMD_PROG_DUMMY) begin
            cmd_b_q  <= CMD_PROG_SECOND;
            settle_q <= BUSY_SETTLE_CYC[2:0];
          end else if (step_done) begin
            cmd_b_q <= 8'h00;
            addr_q  <= addr2_q;
            st_q    <= ST_ADDR2;
          end
        end
        ST_ADDR2: begin
          if (step_done) begin
            acnt_q <= acnt_q + 3'd1;
            if (acnt_q == ncyc_q - 3'd1) begin
              acnt_q <= 3'd0;
              st_q   <= ST_CMD3;
            end
          end
        end
        ST_CMD3:  if (step_done) st_q <= ST_IDLE;
        ST_WDATA: if (step_done) st_q <= ST_IDLE;
        ST_RDATA: if (step_done) st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end

  // Pin drive: strobes, latches and bus value
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_n            <= 1'b1;
      cle             <= 1'b0;
      ale             <= 1'b0;
      wr_strobe_n     <= 1'b1;
      read_strobe_low <= 1'b1;
      wp_n            <= 1'b0;
      io_out          <= 8'h00;
      io_oe_n         <= 1'b1;
    end else begin
      wp_n            <= req_wp_n;
      wr_strobe_n     <= 1'b1;
      read_strobe_low <= 1'b1;
      cle             <= 1'b0;
      ale             <= 1'b0;
      io_oe_n         <= 1'b1;
      // deselect when idle busy runs on
      cs_n            <= (st_q == ST_IDLE);
      case (st_q)
        // command phase bits seven to zero
        ST_CMD1, ST_CMD2, ST_CMD3: begin
          cle         <= 1'b1;
          io_oe_n     <= 1'b0;
          io_out      <= (st_q == ST_CMD1) ? cmd_a_q :
                         (st_q == ST_CMD2) ? cmd_b_q : cmd_c_q;
          wr_strobe_n <= (phase_q != 2'd1);
        end
        ST_ADDR1, ST_ADDR2: begin
          ale         <= 1'b1;
          io_oe_n     <= 1'b0;
          io_out      <= addr_byte(addr_q, acnt_q);
          wr_strobe_n <= (phase_q != 2'd1);
        end
        ST_WDATA: begin
          io_oe_n     <= 1'b0;
          io_out      <= req_wdata_q;
          wr_strobe_n <= (phase_q != 2'd1);
        end
        ST_RDATA: read_strobe_low <= (phase_q != 2'd1);
        default: io_out <= io_out;
      endcase
    end
  end

  // Read byte taken two clocks after its strobe, once the sync chain holds it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_pipe_q  <= 2'b00;
      resp_valid <= 1'b0;
      resp_data  <= 8'h00;
    end else begin
      rd_pipe_q  <= {rd_pipe_q[0], (st_q == ST_RDATA) && step_done};
      resp_valid <= rd_pipe_q[1];
      if (rd_pipe_q[1]) begin
        resp_data <= io_in_s;
      end
    end
  end

  // User status outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      req_ready <= 1'b0;
      dev_ready <= 1'b0;
    end else begin
      dev_ready <= rb_s;
      // Not ready while a read byte is still in flight
      req_ready <= (st_q == ST_IDLE) && !req_valid && (rd_pipe_q == 2'b00);
    end
  end

  // command strobe falls with address latch low, chip selected, read strobe high
  a_cmd_latch: assert property (@(posedge clk) disable iff (!rstn)
    ($fell(wr_strobe_n) && cle) |-> (!ale && !cs_n && read_strobe_low))
    else $error("command strobe without proper latches");

  a_addr_latch: assert property (@(posedge clk) disable iff (!rstn)
    ($fell(wr_strobe_n) && ale) |-> (!cle && !cs_n))
    else $error("address strobe without proper latches");

  // upper nibble low in second and fifth cycles
  a_addr_nibble: assert property (@(posedge clk) disable iff (!rstn)
    (ale && !wr_strobe_n && (st_q == ST_ADDR1 || st_q == ST_ADDR2) &&
     (acnt_q == 3'd1 || acnt_q == 3'd4)) |-> (io_out[7:4] == 4'h0))
    else $error("address upper nibble not low");

  // data strobes only with protect released
  a_wp_data: assert property (@(posedge clk) disable iff (!rstn)
    ($fell(wr_strobe_n) && !cle && !ale) |-> wp_n)
    else $error("data written while protected");

  // read strobe low returns high within eight clocks
  a_rd_pulse: assert property (@(posedge clk) disable iff (!rstn)
    $fell(read_strobe_low) |-> ##[1:8] read_strobe_low)
    else $error("read strobe stuck low");

  a_read_cfg: assert property (@(posedge clk) disable iff (!rstn)
    (cle && !wr_strobe_n && io_out == CMD_READ_CONFIRM) |-> (op_q == OP_READ))
    else $error("read confirm out of sequence");

  // second plane uses plane bit set
  a_plane_bit: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == ST_ADDR2 && op_q == OP_PROG2) |-> addr_q[PLANE_BIT])
    else $error("second plane address bit clear");

  a_bus_float: assert property (@(posedge clk) disable iff (!rstn)
    cs_n |-> io_oe_n)
    else $error("bus driven while deselected");
endmodule

/* File: include/nand_host_pkg.sv */
// Package: NAND host command codes, pin timing and sequencing constants
package nand_host_pkg;

  // Command codes
  localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_PROG_DUMMY   = 8'h11;
  localparam logic [7:0] CMD_PROG_SECOND  = 8'h81;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF   = 8'hd0;
  localparam logic [7:0] CMD_STATUS       = 8'h70;
  localparam logic [7:0] CMD_RESET        = 8'hff;
  localparam logic [7:0] CMD_RAND_IN      = 8'h85;
  localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_CF  = 8'he0;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;

  // Operation requests from the user side
  typedef enum logic [3:0] {
    OP_READ, OP_PROG, OP_PROG2, OP_ERASE, OP_ERASE2, OP_STATUS, OP_RESET,
    OP_RAND_IN, OP_RAND_OUT, OP_READ_ID, OP_DATA_WR, OP_DATA_RD, OP_PROG_GO
  } op_e;

  // Address layout
  localparam int ADDR_CYCLES = 5;
  localparam int ADDR_W      = 32;
  localparam int COL_CYCLES  = 2;
  localparam int PLANE_BIT   = 19;
  localparam int ID_BYTES    = 5;

  // Array geometry
  localparam int BLOCKS     = 16384;
  localparam int PAGES      = 128;
  localparam int PAGE_BYTES = 2112;

  // Strobe phase timing: each low and high half of a strobe
  localparam int CLK_PERIOD_NS = 50;
  localparam int STROBE_NS     = 50;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Clocks after 11h before the ready line is trusted
  localparam int BUSY_SETTLE_CYC = 4;

endpackage

/* File: rtl/nand_pin_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module nand_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rstn,   // Sync reset, active low
  input  wire logic [W-1:0] d,      // Asynchronous input
  input  wire logic [W-1:0] rst_val,// Value held during reset
  output logic      [W-1:0] q       // Synchronised output
);
  logic [W-1:0] meta_q;             // First stage, read only by second

  // Two stages, reset to a given level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= rst_val;
      q      <= rst_val;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* File: test/nand_dev_model.sv */
// Behavioural model of the flash device on the far side of the host pins
`timescale 1ns/10ps
module nand_dev_model
  import nand_host_pkg::*;
#(
  parameter int          BUSY_CYC = 120,   // Array busy time in clocks
  parameter logic [39:0] ID_V     = 40'h0  // Signature bytes, first in low byte
) (
  input  wire logic       clk,   // Bench clock, times busy only
  input  wire logic       cs_n,  // Chip select
  input  wire logic       cle,   // Command latch strobe
  input  wire logic       ale,   // Address latch strobe
  input  wire logic       we_n,  // Write strobe
  input  wire logic       rd_n,  // Read strobe
  input  wire logic       wp_n,  // Write protect
  input  wire logic [7:0] dq,    // Resolved bus level
  output logic      [7:0] q,     // Byte driven back
  output logic            q_en,  // Model drives the bus
  output logic            busy   // Pulls the wired ready line low
);
  // one page register of full page size
  logic [7:0]  page [0:PAGE_BYTES-1];
  logic [31:0] addr;          // Assembled address
  logic [31:0] hist = 0;      // Last four commands
  logic [11:0] col = 0;       // Column pointer
  logic        a19_first;     // Plane bit of first page
  logic        rd_seen = 0;   // Output phase open
  int          mode = 0;      // 0 data, 1 status, 2 signature
  int          acnt, idx, starts = 0, seen = 0, cnt = 0, bad = 0, viol = 0;
  assign busy = cnt != 0;
  // inputs latched on write strobe rise
  always @(posedge we_n) begin
    if (!cs_n && rd_n) begin
      if (cle && !ale) begin
        // count commands that are illegal while busy
        if (busy && dq != 8'h70 && dq != 8'hff) bad++;
        hist = {hist[23:0], dq};
        acnt = 0;
        if (dq == 8'h70) mode = 1;
        if (dq == 8'h90) begin
          mode = 2;
          idx = 0;
        end
        if (dq == 8'h00 || dq == 8'h05) mode = 0;
        if (dq == 8'h11) a19_first = addr[19];
        // confirms start busy, modify ones need wp high
        if (dq == 8'h30 || dq == 8'hff ||
            (wp_n && (dq == 8'h10 || dq == 8'h11 || dq == 8'hd0))) starts++;
      end else if (ale && !cle) begin
        // byte lanes, spare nibbles must be low
        case (acnt)
          0: addr[7:0] = dq;
          1: begin
            addr[11:8] = dq[3:0];
            col = {dq[3:0], addr[7:0]};
          end
          2: addr[19:12] = dq;
          3: addr[27:20] = dq;
          default: addr[31:28] = dq[3:0];
        endcase
        if ((acnt == 1 || acnt == 4) && dq[7:4] != 4'h0) viol++;
        acnt++;
      end else if (!cle && !ale && wp_n) begin
        // data loads at the column pointer
        page[col] = dq;
        col++;
      end
    end
  end
  // next byte on read strobe fall
  always @(negedge rd_n) begin
    if (!cs_n) begin
      rd_seen = 1;
      if (mode == 1) q = {wp_n, !busy, 6'h00};
      else if (mode == 2) begin
        q = ID_V[idx*8 +: 8];
        idx = (idx + 1) % 5;
      end else begin
        q = page[col];
        col++;
      end
    end
  end
  // Output phase ends with the next write strobe
  always @(negedge we_n) rd_seen = 0;
  assign q_en = !cs_n && !cle && !ale && we_n && rd_seen;
  // busy runs out whatever chip select does
  always @(posedge clk) begin
    if (seen != starts) begin
      seen = starts;
      cnt = BUSY_CYC;
    end else if (cnt != 0) cnt--;
  end
endmodule

/* File: test/tb_nand_command_address_port.sv */
// Self-checking bench for the NAND host controller
`timescale 1ns/10ps
module tb_nand_command_address_port;
  import nand_host_pkg::*;
  localparam logic [39:0] ID_V = 40'h5a_c3_96_3c_e1; // Arbitrary signature
  logic        clk = 0, rstn = 0, req_valid = 0, req_wp_n = 1;
  op_e         req_op = OP_STATUS;
  logic [31:0] req_addr = 0, req_addr2 = 0;
  logic [7:0]  req_wdata = 0, resp_data, io_out, io_in, q, got;
  logic        req_ready, resp_valid, req_refused, dev_ready, cs_n, cle, ale;
  logic        we_n, rd_n, wp_n, io_oe_n, q_en, busy, refused;
  int          error_cnt = 0, total_checks = 0, seed = 32'ha4bb;
  always #25 clk = ~clk;
  // Released bus shows the inverse of the last byte
  assign io_in = !io_oe_n ? io_out : (q_en ? q : ~q);
  nand_host_ctrl #(.STROBE_CYCLES(1)) dut (.clk, .rstn, .req_valid, .req_op, .req_addr,
    .req_addr2, .req_wdata, .req_wp_n, .req_ready, .resp_valid, .resp_data, .req_refused,
    .dev_ready, .cs_n, .cle, .ale, .wr_strobe_n(we_n), .read_strobe_low(rd_n), .wp_n,
    .io_out, .io_oe_n, .io_in, .rb_in(!busy));
  nand_dev_model #(.BUSY_CYC(120), .ID_V(ID_V)) dev (.clk, .cs_n, .cle, .ale, .we_n,
    .rd_n, .wp_n, .dq(io_in), .q, .q_en, .busy);
  // Compare and count
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One bounded clock step
  task automatic tick(inout int i);
    @(posedge clk);
    #1;
    i++;
    if (i > 2000) begin
      chk("wait bound", 0, 1);
      tally_and_finish();
    end
  endtask
  // Wait for the ready line after busy has had time to show
  task automatic wait_rdy();
    int i;
    i = 0;
    repeat (8) @(posedge clk);
    while (dev_ready !== 1'b1) tick(i);
  endtask
  // One user operation, collecting refusal and read byte
  task automatic do_op(op_e op, logic [31:0] a, logic [31:0] a2 = 0,
                       logic [7:0] w = 0, logic wp = 1);
    int i;
    i = 0;
    refused = 0;
    got = 8'hxx;
    while (req_ready !== 1'b1) tick(i);
    @(posedge clk);
    req_valid <= 1;
    req_op <= op;
    req_addr <= a;
    req_addr2 <= a2;
    req_wdata <= w;
    req_wp_n <= wp;
    @(posedge clk);
    req_valid <= 0;
    #1;
    if (req_refused === 1'b1) refused = 1;
    i = 0;
    do begin
      tick(i);
      if (resp_valid === 1'b1) got = resp_data;
      if (req_refused === 1'b1) refused = 1;
    end while (i < 3 || req_ready !== 1'b1);
  endtask
  initial begin
    logic [31:0] a, c;
    logic [7:0]  d [4];
    op_e         tops [4] = '{OP_ERASE, OP_ERASE2, OP_RESET, OP_PROG2};
    logic [31:0] texp [4] = '{32'h60d0, 32'h6060d0, 32'hff, 32'h80118110};
    logic [31:0] tmsk [4] = '{32'hffff, 32'hffffff, 32'hff, 32'hffffffff};
    int          s0;
    repeat (6) @(posedge clk);
    chk("cs_n in reset", cs_n, 1);
    chk("bus released", io_oe_n, 1);
    rstn <= 1;
    // Page reads at random addresses
    for (int k = 0; k < 3; k++) begin
      a = $random(seed);
      s0 = dev.starts;
      do_op(OP_READ, a);
      wait_rdy();
      chk("read cmds", dev.hist[15:0], 16'h0030);
      chk("address", dev.addr, a);
      chk("spare nibbles", dev.viol, 0);
      chk("busy pulses", dev.starts - s0, 1);
    end
    $display("test page read done");
    // Program entry, moved input column, moved output column
    a = $random(seed) & 32'hffff_f7ff;
    do_op(OP_PROG, a);
    chk("prog cmd", dev.hist[7:0], 8'h80);
    for (int k = 0; k < 4; k++) begin
      d[k] = $random(seed);
      do_op(OP_DATA_WR, 0, 0, d[k]);
      chk("data in", dev.page[a[11:0] + k], d[k]);
    end
    c = {20'h0, a[11:0] ^ 12'h400};
    do_op(OP_RAND_IN, c);
    do_op(OP_DATA_WR, 0, 0, 8'h5a);
    chk("moved column", dev.page[c[11:0]], 8'h5a);
    do_op(OP_RAND_OUT, a);
    for (int k = 0; k < 4; k++) begin
      do_op(OP_DATA_RD, 0);
      chk("data out", got, d[k]);
    end
    do_op(OP_PROG_GO, 0);
    chk("prog confirm", dev.hist[7:0], 8'h10);
    wait_rdy();
    $display("test column moves done");
    // Signature bytes
    do_op(OP_READ_ID, 0);
    for (int k = 0; k < 5; k++) begin
      do_op(OP_DATA_RD, 0);
      chk("signature", got, ID_V[k*8 +: 8]);
    end
    $display("test signature done");
    // Array command sequences
    for (int k = 0; k < 4; k++) begin
      a = $random(seed) & 32'hfff7_ffff;
      do_op(tops[k], a, a | 32'h0008_0000);
      wait_rdy();
      chk("sequence", dev.hist & tmsk[k], texp[k]);
    end
    chk("first plane", dev.a19_first, 0);
    chk("second plane", dev.addr[19], 1);
    $display("test command sequences done");
    // Status while busy, refusal while busy
    do_op(OP_ERASE, a);
    repeat (8) @(posedge clk);
    chk("busy line", dev_ready, 0);
    do_op(OP_STATUS, 0);
    chk("status taken", refused, 0);
    do_op(OP_DATA_RD, 0);
    chk("busy status", got[6:0], 7'h00);
    do_op(OP_ERASE, a);
    chk("busy refuse", refused, 1);
    chk("no busy command", dev.bad, 0);
    wait_rdy();
    do_op(OP_DATA_RD, 0);
    chk("ready status", got[6:0], 7'h40);
    $display("test busy handling done");
    // Write protect blocks an erase request
    c = dev.hist;
    do_op(OP_ERASE, a, a, 0, 0);
    chk("wp refuse", refused, 1);
    chk("no erase sent", dev.hist, c);
    $display("test write protect done");
    tally_and_finish();
  end
endmodule
